// ---- bench/rsled_port_src.sv ----
// Port status source model: serial and Ethernet flags as port logic reports them.
// Assumes callers step it from the clock's rising edge.
`timescale 1ns/1ps
`default_nettype none
module rsled_port_src
	import rsled_pkg::*;
#(
	parameter int FE_PORTS = 6
) (
	input wire logic clk_sys, // Clock.
	output var logic [SER_PORTS-1:0] ser_active, // Serial active.
	output var logic [SER_PORTS-1:0] ser_loopback, // Serial loopback.
	output var logic [FE_PORTS-1:0] fe_link_up, // Link up.
	output var logic [FE_PORTS-1:0] fe_activity // Activity.
);
	initial begin
		{ser_loopback, ser_active, fe_link_up, fe_activity} = '0;
	end
	task set_ports(input logic [3:0] s, input logic [FE_PORTS-1:0] l, input logic [FE_PORTS-1:0] a);
		@(posedge clk_sys);
		{ser_loopback, ser_active} <= s;
		fe_link_up <= l;
		fe_activity <= a;
	endtask : set_ports
endmodule : rsled_port_src
`default_nettype wire

// ---- bench/rsled_sva.sv ----
// Checker on the status LED driver ports.
// Assumes the bench holds port flags steady for whole blink periods.
`timescale 1ns/1ps
`default_nettype none
module rsled_sva
	import rsled_pkg::*;
#(
	parameter int FE_PORTS = 6,
	parameter int BLINK_HALF = 4
) (
	input wire logic clk_sys, // Clock.
	input wire logic rstn, // Reset, active low.
	input wire logic avs_read, // Read request.
	input wire logic avs_write, // Write request.
	input wire logic avs_waitrequest, // Stall.
	input wire logic [SER_PORTS-1:0] ser_active, // Serial active.
	input wire logic [SER_PORTS-1:0] ser_loopback, // Serial loopback.
	input wire logic [FE_PORTS-1:0] fe_link_up, // Link up.
	input wire logic [FE_PORTS-1:0] fe_activity, // Activity.
	input wire rsled_strength_type strength_led_q, // Strength LEDs.
	input wire logic [SER_PORTS-1:0] ser_state_green_q, // Serial state LED.
	input wire logic [SER_PORTS-1:0] ser_loop_yellow_q, // Serial loopback LED.
	input wire logic [FE_PORTS-1:0] fe_link_green_q, // Link LED.
	input wire logic [FE_PORTS-1:0] fe_act_yellow_q // Activity LED.
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	if (BLINK_HALF != 4) begin : g_half_check
		$error("blink checks need a half period of four cycles");
	end
	// The run of four cycles equals the half period the bench sets.
	sequence act_run;
		fe_activity[0] [*4];
	endsequence
	sequence act_before;
		$past(fe_activity[0]) && $past(fe_activity[0], 2);
	endsequence
	a_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus stall longer than one cycle");
	a_bus_idle_wait: assert property (!avs_read && !avs_write |=> avs_waitrequest)
		else $error("wait dropped without request");
	a_strength_legal: assert property ({strength_led_q} inside {6'h15, 6'h16, 6'h14, 6'h18, 6'h10, 6'h20, 6'h00})
		else $error("strength pattern outside table");
	a_ser_state: assert property ($past(rstn) |-> ser_state_green_q == $past(ser_active & ~ser_loopback))
		else $error("serial state LED wrong");
	a_ser_loop: assert property ((ser_loop_yellow_q & ~$past(ser_loopback)) == '0)
		else $error("loopback LED lit outside loopback");
	a_fe_link: assert property ($past(rstn) |-> fe_link_green_q == $past(fe_link_up))
		else $error("link LED wrong");
	a_fe_act: assert property ((fe_act_yellow_q & ~$past(fe_activity)) == '0)
		else $error("activity LED lit while idle");
	a_blink_shared: assert property ($past(ser_loopback[0]) && $past(fe_activity[0]) |->
		ser_loop_yellow_q[0] == fe_act_yellow_q[0]) else $error("blink phases differ");
	a_blink_on_half: assert property (act_before ##0 $rose(fe_act_yellow_q[0]) ##0 act_run |->
		fe_act_yellow_q[0] ##1 !fe_act_yellow_q[0]) else $error("lit half wrong length");
	a_blink_off_half: assert property (act_before ##0 $fell(fe_act_yellow_q[0]) ##0 act_run |->
		!fe_act_yellow_q[0] ##1 fe_act_yellow_q[0]) else $error("dark half wrong length");
endmodule : rsled_sva
bind rsled_top rsled_sva #(.FE_PORTS(FE_PORTS), .BLINK_HALF(BLINK_HALF)) rsled_sva_inst (.clk_sys(clk_sys),
	.rstn(rstn), .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
	.ser_active(ser_active), .ser_loopback(ser_loopback), .fe_link_up(fe_link_up), .fe_activity(fe_activity),
	.strength_led_q(strength_led_q), .ser_state_green_q(ser_state_green_q), .ser_loop_yellow_q(ser_loop_yellow_q),
	.fe_link_green_q(fe_link_green_q), .fe_act_yellow_q(fe_act_yellow_q));
`default_nettype wire

// ---- bench/testbench.sv ----
// Self-checking bench for the status LED driver.
// Drives the register bus and port flags by non-blocking writes on the rising edge.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import rsled_pkg::*;
	localparam int HB = 4;
	logic clk_sys, rstn, avs_read, avs_write, avs_waitrequest;
	logic [ADDR_W-1:0] avs_address;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata, rv;
	rsled_strength_type strength_led_q;
	logic [1:0] sa, sl, sg, sy;
	logic [5:0] fl, fa, fg, fy;
	int fails, cmp_count, n0, n1;
	rsled_top #(.FE_PORTS(6), .BLINK_HALF(HB)) rsled_top_inst (.clk_sys(clk_sys), .rstn(rstn),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.ser_active(sa),
		.ser_loopback(sl), .fe_link_up(fl), .fe_activity(fa), .strength_led_q(strength_led_q),
		.ser_state_green_q(sg), .ser_loop_yellow_q(sy), .fe_link_green_q(fg), .fe_act_yellow_q(fy));
	rsled_port_src #(.FE_PORTS(6)) rsled_port_src_inst (.clk_sys(clk_sys), .ser_active(sa), .ser_loopback(sl),
		.fe_link_up(fl), .fe_activity(fa));
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	task chk_reg(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %0t register got %h expected %h", $time, g, e);
		end
	endtask : chk_reg
	task chk_led(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %0t LEDs got %h expected %h", $time, g, e);
		end
	endtask : chk_led
	// Read data is taken at the same edge that shows waitrequest low.
	task bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
		rv = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		repeat (3) @(posedge clk_sys);
	endtask : bus
	task blink_count;
		n0 = 0;
		n1 = 0;
		repeat (2 * HB) begin
			@(posedge clk_sys);
			n0 += sy[0];
			n1 += fy[0];
		end
	endtask : blink_count
	function automatic logic [7:0] pat(input int b);
		case (b)
			5: pat = 8'h15;
			4: pat = 8'h16;
			3: pat = 8'h14;
			2: pat = 8'h18;
			1: pat = 8'h10;
			default: pat = 8'h20;
		endcase
	endfunction : pat
	task report_and_stop;
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (20000) @(posedge clk_sys);
		fails++;
		report_and_stop();
	end
	initial begin
		rstn = 1'b0;
		{avs_read, avs_write, avs_address, avs_writedata} = '0;
		avs_byteenable = 4'hf;
		fails = 0;
		cmp_count = 0;
		repeat (12) @(posedge clk_sys);
		rstn <= 1'b1;
		bus(0, REG_CTRL, 0);
		chk_reg(rv, CTRL_RESET);
		chk_led({2'b0, strength_led_q}, 8'h00);
		bus(0, REG_THRESH, 0);
		chk_reg(rv, THRESH_RESET);
		bus(0, 4'h2, 0);
		chk_reg(rv, 32'h0);
		$display("test reset done");
		for (int b = 0; b <= 5; b++) begin
			bus(1, REG_CTRL, 32'h40 | b);
			chk_led({2'b0, strength_led_q}, pat(b));
			bus(0, REG_STATUS, 0);
			chk_reg({26'h0, rv[5:0]}, {24'h0, pat(b)});
			chk_reg(32'(rv[10:8]), 32'(b));
		end
		bus(1, REG_CTRL, 32'h47);
		chk_led({2'b0, strength_led_q}, pat(5));
		bus(1, REG_CTRL, 32'h0);
		chk_led({2'b0, strength_led_q}, 8'h00);
		$display("test manual bars done");
		bus(1, REG_METRIC, 32'h00c8_c85f);
		bus(1, REG_CTRL, 32'hd0);
		chk_led({2'b0, strength_led_q}, pat(3));
		bus(1, REG_CTRL, 32'he0);
		chk_led({2'b0, strength_led_q}, pat(0));
		bus(1, REG_METRIC, 32'h0073_50c8);
		chk_led({2'b0, strength_led_q}, pat(1));
		bus(1, REG_METRIC, 32'h0050_73c8);
		chk_led({2'b0, strength_led_q}, pat(1));
		bus(0, REG_METRIC, 0);
		chk_reg(rv, 32'h0050_73c8);
		avs_byteenable <= 4'h2;
		bus(1, REG_THRESH, 32'hffff_14ff);
		avs_byteenable <= 4'hf;
		bus(0, REG_THRESH, 0);
		chk_reg(rv, 32'h0000_1450);
		$display("test derived bars done");
		rsled_port_src_inst.set_ports(4'b0111, 6'b101001, 6'b000001);
		repeat (3) @(posedge clk_sys);
		chk_led({6'h0, sg}, 8'h02);
		chk_led({2'h0, fg}, 8'h29);
		repeat (2) begin
			blink_count();
			chk_reg(32'(n0), 32'(HB));
			chk_reg(32'(n1), 32'(HB));
			chk_led({2'b0, fy[5:1], sy[1]}, 8'h00);
		end
		rsled_port_src_inst.set_ports(4'b0000, 6'b0, 6'b0);
		repeat (3) @(posedge clk_sys);
		chk_led({fg, sy}, 8'h00);
		chk_led({fy, sg}, 8'h00);
		$display("test port LEDs done");
		rsled_port_src_inst.set_ports(4'b0011, 6'b000011, 6'b0);
		repeat (3) @(posedge clk_sys);
		rstn <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk_led({fg, sg}, 8'h00);
		chk_led({2'b0, strength_led_q}, 8'h00);
		rstn <= 1'b1;
		repeat (2) @(posedge clk_sys);
		chk_led({fg, sg}, 8'h0f);
		bus(0, REG_THRESH, 0);
		chk_reg(rv, THRESH_RESET);
		bus(0, REG_CTRL, 0);
		chk_reg(rv, CTRL_RESET);
		$display("test mid-run reset done");
		report_and_stop();
	end
endmodule : testbench
`default_nettype wire

// ---- core/rsled_bars.sv ----
// Signal bar estimator: maps modem power reports to a bar count of 0 to 5.
// Assumes reports are magnitudes in dB below 0 dBm; smaller is stronger.
`timescale 1ns/1ps
`default_nettype none
module rsled_bars
	import rsled_pkg::*;
(
	input wire rsled_metric_type metric, // Modem reports.
	input wire rsled_net_type net, // Attached network.
	input wire logic [7:0] best, // Magnitude that gives five bars.
	input wire logic [7:0] step, // Magnitude step between bars.
	output logic [2:0] bars // Derived bar count.
);
	function automatic logic [2:0] grade(input logic [7:0] mag, input logic [7:0] b, input logic [7:0] s);
		logic [10:0] lim;
		logic [2:0] n;
		lim = {3'h0, b};
		n = 3'h5;
		for (int i = 0; i < 5; i++) begin
			if (n == 3'(5 - i) && {3'h0, mag} > lim) begin
				n = 3'(4 - i);
			end
			lim = lim + {3'h0, s};
		end
		return n;
	endfunction

	logic [2:0] g_rscp;
	logic [2:0] g_rssi;

	always_comb begin
		g_rscp = grade(metric.rscp, best, step);
		g_rssi = grade(metric.rssi, best, step);
		case (net)
			RSLED_NET_LTE: bars = grade(metric.rsrp, best, step);
			// A 3G link is only as good as the weaker of its two reports.
			RSLED_NET_3G: bars = (g_rscp < g_rssi) ? g_rscp : g_rssi;
			default: bars = 3'h0;
		endcase
	end

endmodule : rsled_bars
`default_nettype wire

// ---- core/rsled_blink.sv ----
// Shared blink divider: a square wave with equal on and off time.
// Assumes one clock domain; the half period counts whole clock cycles.
`timescale 1ns/1ps
`default_nettype none
module rsled_blink
	import rsled_pkg::*;
#(
	parameter int HALF_CYC = BLINK_HALF_CYC
) (
	input wire logic clk_sys, // System clock.
	input wire logic rstn, // Asynchronous reset, active low.
	output logic blink // Blink phase, high in the lit half.
);
	localparam int CW = $clog2(HALF_CYC + 1);

	logic [CW-1:0] cnt_q;

	if (HALF_CYC < 1) begin : g_half_check
		$error("HALF_CYC must be at least one");
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= '0;
			blink <= 1'b0;
		end else if (cnt_q == CW'(HALF_CYC - 1)) begin
			cnt_q <= '0;
			blink <= ~blink;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

endmodule : rsled_blink
`default_nettype wire

// ---- core/rsled_pkg.sv ----
// Package for the router status LED driver: register map, colour codes, field layout and timing.
// Assumes a 20 MHz system clock and a 32-bit Avalon-MM register bus with byte addresses.
package rsled_pkg;

	localparam int CLK_HZ = 20000000;
	// Half period of every blink, in milliseconds; equal on and off time.
	localparam int BLINK_HALF_MS = 250;
	localparam int BLINK_HALF_CYC = (CLK_HZ / 1000) * BLINK_HALF_MS;

	localparam int FE_PORTS_MAX = 6;
	localparam int SER_PORTS = 2;
	localparam int ADDR_W = 4;

	// Register byte offsets.
	localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] REG_METRIC = 4'h4;
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'h8;
	localparam logic [ADDR_W-1:0] REG_THRESH = 4'hc;

	// CTRL fields.
	localparam int CTRL_BARS_LSB = 0;
	localparam int CTRL_NET_LSB = 4;
	localparam int CTRL_CELL_EN_BIT = 6;
	localparam int CTRL_AUTO_BIT = 7;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0080;

	// METRIC fields: three modem reports, each a magnitude in dB below 0 dBm.
	localparam int MET_RSRP_LSB = 0;
	localparam int MET_RSCP_LSB = 8;
	localparam int MET_RSSI_LSB = 16;

	// THRESH: step between bars, and the magnitude at which five bars are reached.
	localparam logic [31:0] THRESH_RESET = 32'h0000_0a50;

	typedef enum logic [1:0] {RSLED_NET_NONE, RSLED_NET_LTE, RSLED_NET_3G} rsled_net_type;

	typedef enum logic [1:0] {RSLED_OFF, RSLED_GREEN, RSLED_YELLOW} rsled_colour_type;

	typedef struct packed {
		logic [7:0] rsrp;
		logic [7:0] rscp;
		logic [7:0] rssi;
	} rsled_metric_type;

	typedef struct packed {
		rsled_colour_type left;
		rsled_colour_type middle;
		rsled_colour_type right;
	} rsled_strength_type;

endpackage : rsled_pkg

// ---- core/rsled_top.sv ----
// Router front-panel status LED driver: signal strength, serial and Fast Ethernet LEDs.
// Assumes an Avalon-MM master on the register bus and port status flags synchronous to clk_sys.
//
// The Avalon-MM register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module rsled_top
	import rsled_pkg::*;
#(
	parameter int FE_PORTS = FE_PORTS_MAX,
	parameter int BLINK_HALF = BLINK_HALF_CYC
) (
	input wire logic clk_sys, // System clock, 20 MHz.
	input wire logic rstn, // Asynchronous reset, active low.
	input wire logic [ADDR_W-1:0] avs_address, // Register byte address.
	input wire logic avs_read, // Read request.
	input wire logic avs_write, // Write request.
	input wire logic [31:0] avs_writedata, // Write data.
	input wire logic [3:0] avs_byteenable, // Write byte lanes.
	output logic [31:0] avs_readdata, // Read data.
	output logic avs_waitrequest, // Stall, high until the access is served.
	input wire logic [SER_PORTS-1:0] ser_active, // Serial port active.
	input wire logic [SER_PORTS-1:0] ser_loopback, // Serial port in loopback.
	input wire logic [FE_PORTS-1:0] fe_link_up, // Ethernet link operationally up.
	input wire logic [FE_PORTS-1:0] fe_activity, // Ethernet receiving or transmitting.
	output rsled_strength_type strength_led_q, // Three strength LED colours.
	output logic [SER_PORTS-1:0] ser_state_green_q, // Serial state LED green.
	output logic [SER_PORTS-1:0] ser_loop_yellow_q, // Serial loopback LED yellow.
	output logic [FE_PORTS-1:0] fe_link_green_q, // Ethernet link LED green.
	output logic [FE_PORTS-1:0] fe_act_yellow_q // Ethernet activity LED yellow.
);
	// The alarms and console ports have no indicator outputs at all.

	if (FE_PORTS != 3 && FE_PORTS != FE_PORTS_MAX) begin : g_ports_check
		$error("FE_PORTS must be 3 or 6");
	end

	logic [31:0] ctrl_q;
	logic [31:0] metric_q;
	logic [31:0] thresh_q;
	logic served_q;
	logic blink;
	logic [2:0] auto_bars;
	logic [2:0] bars;
	rsled_net_type net;
	rsled_strength_type strength_d;
	rsled_metric_type metric;

	// One wait state: the access is served on the second cycle it is held.
	// Holding waitrequest high by default keeps the slave simple and timing-safe.
	// Waitrequest has its own flop, always the inverse of served_q, so the pin has no gate after it.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			served_q <= 1'b0;
			avs_waitrequest <= 1'b1;
		end else begin
			served_q <= (avs_read || avs_write) && !served_q;
			avs_waitrequest <= !((avs_read || avs_write) && !served_q);
		end
	end

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ctrl_q <= CTRL_RESET;
			metric_q <= 32'h0;
			thresh_q <= THRESH_RESET;
		end else if (avs_write && served_q) begin
			case (avs_address)
				REG_CTRL: ctrl_q <= merge(ctrl_q, avs_writedata, avs_byteenable) & 32'h0000_00ff;
				REG_METRIC: metric_q <= merge(metric_q, avs_writedata, avs_byteenable) & 32'h00ff_ffff;
				REG_THRESH: thresh_q <= merge(thresh_q, avs_writedata, avs_byteenable) & 32'h0000_ffff;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			avs_readdata <= 32'h0;
		end else if (avs_read && !served_q) begin
			case (avs_address)
				REG_CTRL: avs_readdata <= ctrl_q;
				REG_METRIC: avs_readdata <= metric_q;
				REG_STATUS: avs_readdata <= {21'h0, bars, 2'h0, strength_led_q};
				REG_THRESH: avs_readdata <= thresh_q;
				default: avs_readdata <= 32'h0;
			endcase
		end
	end

	always_comb begin
		metric.rsrp = metric_q[MET_RSRP_LSB +: 8];
		metric.rscp = metric_q[MET_RSCP_LSB +: 8];
		metric.rssi = metric_q[MET_RSSI_LSB +: 8];
		case (ctrl_q[CTRL_NET_LSB +: 2])
			2'h1: net = RSLED_NET_LTE;
			2'h2: net = RSLED_NET_3G;
			default: net = RSLED_NET_NONE;
		endcase
	end

	rsled_bars u_bars (
		.metric(metric),
		.net(net),
		.best(thresh_q[7:0]),
		.step(thresh_q[15:8]),
		.bars(auto_bars)
	);

	rsled_blink #(
		.HALF_CYC(BLINK_HALF)
	) u_blink (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.blink(blink)
	);

	always_comb begin
		if (ctrl_q[CTRL_AUTO_BIT]) begin
			bars = auto_bars;
		end else if (ctrl_q[CTRL_BARS_LSB +: 3] > 3'h5) begin
			bars = 3'h5;
		end else begin
			bars = ctrl_q[CTRL_BARS_LSB +: 3];
		end
		case (bars)
			3'h5: strength_d = '{RSLED_GREEN, RSLED_GREEN, RSLED_GREEN};
			3'h4: strength_d = '{RSLED_GREEN, RSLED_GREEN, RSLED_YELLOW};
			3'h3: strength_d = '{RSLED_GREEN, RSLED_GREEN, RSLED_OFF};
			3'h2: strength_d = '{RSLED_GREEN, RSLED_YELLOW, RSLED_OFF};
			3'h1: strength_d = '{RSLED_GREEN, RSLED_OFF, RSLED_OFF};
			default: begin
				if (ctrl_q[CTRL_CELL_EN_BIT]) begin
					strength_d = '{RSLED_YELLOW, RSLED_OFF, RSLED_OFF};
				end else begin
					strength_d = '{RSLED_OFF, RSLED_OFF, RSLED_OFF};
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			strength_led_q <= '{RSLED_OFF, RSLED_OFF, RSLED_OFF};
		end else begin
			strength_led_q <= strength_d;
		end
	end

	// A port in loopback never shows green, even if it also reports active.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ser_state_green_q <= '0;
			ser_loop_yellow_q <= '0;
		end else begin
			ser_state_green_q <= ser_active & ~ser_loopback;
			ser_loop_yellow_q <= ser_loopback & {SER_PORTS{blink}};
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			fe_link_green_q <= '0;
			fe_act_yellow_q <= '0;
		end else begin
			fe_link_green_q <= fe_link_up;
			fe_act_yellow_q <= fe_activity & {FE_PORTS{blink}};
		end
	end

endmodule : rsled_top
`default_nettype wire
